// ===== src/breaker_failure_params.svh
// offsets, field positions, reset values and timing figures of the breaker failure decision logic
`ifndef BREAKER_FAILURE_PARAMS_SVH
`define BREAKER_FAILURE_PARAMS_SVH

// ==========================================================
// register offsets
`define BF_CTRL_OFS 8'h00
`define BF_RETRIP_DLY_OFS 8'h04
`define BF_BACKUP_DLY_OFS 8'h08
`define BF_PULSE_OFS 8'h0c
`define BF_PH_THR_OFS 8'h10
`define BF_RES_THR_OFS 8'h14
`define BF_STATUS_OFS 8'h18

// ==========================================================
// control fields
`define BF_CTRL_MODE_LSB 0
`define BF_CTRL_MODE_MSB 1
`define BF_CTRL_RETRIP_BIT 2
`define BF_CTRL_CLEAR_BIT 3

// ==========================================================
// setting ranges and reset values, delays in milliseconds, thresholds in percent
`define BF_RETRIP_MIN 16'h0000
`define BF_RETRIP_MAX 16'h03e8
`define BF_RETRIP_DEF 16'h0064
`define BF_BACKUP_MIN 16'h0064
`define BF_BACKUP_MAX 16'hea60
`define BF_BACKUP_DEF 16'h03e8
`define BF_PULSE_MIN 16'h0000
`define BF_PULSE_MAX 16'hea60
`define BF_PULSE_DEF 16'h0064
`define BF_PH_THR_MIN 16'h0014
`define BF_PH_THR_MAX 16'h00c8
`define BF_PH_THR_DEF 8'h1e
`define BF_RES_THR_MIN 16'h000a
`define BF_RES_THR_MAX 16'h00c8
`define BF_RES_THR_DEF 8'h14

// ==========================================================
// timing: millisecond tick from the core clock
`define BF_TICK_US 1000
`define BF_CLK_MHZ 250

`endif

// ===== src/breaker_failure_pkg.sv
// types shared by the breaker failure decision logic
`default_nettype none
package breaker_failure_pkg;
	typedef enum logic [1:0] {
		OP_OFF,
		OP_CURRENT,
		OP_CONTACT,
		OP_BOTH
	} op_mode_t;
endpackage
`default_nettype wire

// ===== src/breaker_failure_decision_logic.sv
// breaker failure decision logic: start timers, supervision, backup trip and per-phase retrip
`include "breaker_failure_params.svh"
`default_nettype none

// Functional notes
// - a start rising edge launches separate backup and retrip timers per phase.
// - current mode judges failure from phase and residual flags only.
// - contact mode judges failure from breaker-closed inputs only, per phase if single-pole.
// - combined mode watches both; resets only when current low and breaker open.
// - mode off disables the block; no trip outputs.
// - backup timer expiry with failure persisting asserts backup trip.
// - each trip output stays high at least the pulse-duration setting.
// - retrip enabled: phase retrip asserts when its retrip timer expires with failure.
// - block input suppresses operation and all trip outputs.
// - common-phase variant: one start, one breaker-closed, backup trip only.
// - single-pole variant: three starts, three breaker-closed inputs, three retrip outputs.
// - per-phase overcurrent flags plus residual overcurrent flag supervise current.
// - retrip delay 0 to 1000 ms, 1 ms steps, default 100.
// - backup delay 100 to 60000 ms, 1 ms steps, default 1000.
// - pulse duration 0 to 60000 ms, 1 ms steps, default 100.
// - phase threshold 20 to 200 percent, residual 10 to 200, default 30/20.
module breaker_failure_decision_logic
	import breaker_failure_pkg::*;
#(
	parameter bit SINGLE_POLE = 1'b1,
	parameter int unsigned TICK_CYCLES = `BF_TICK_US * `BF_CLK_MHZ
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic block_in_i,
	input wire logic common_start_in_i,
	input wire logic start_ph1_i,
	input wire logic start_ph2_i,
	input wire logic start_ph3_i,
	input wire logic residual_start_in_i,
	input wire logic breaker_closed_in_i,
	input wire logic breaker_closed_ph1_i,
	input wire logic breaker_closed_ph2_i,
	input wire logic breaker_closed_ph3_i,
	input wire logic over_current_ph1_i,
	input wire logic over_current_ph2_i,
	input wire logic over_current_ph3_i,
	input wire logic over_current_res_i,
	output logic [7:0] phase_threshold_o,
	output logic [7:0] residual_threshold_o,
	output logic backup_trip_out_o,
	output logic retrip_ph1_o,
	output logic retrip_ph2_o,
	output logic retrip_ph3_o
);
	// channels 0..2 are the phases, channel 3 is the residual start
	localparam int NCH = 4;
	localparam int TW = $clog2(TICK_CYCLES + 1);
	function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
		logic [15:0] r;
		if (v < {16'h0000, lo}) begin
			r = lo;
		end else if (v > {16'h0000, hi}) begin
			r = hi;
		end else begin
			r = v[15:0];
		end
		return r;
	endfunction

	// ==========================================================
	// register file
	op_mode_t mode_q, mode_d;
	logic retrip_en_q, retrip_en_d;
	logic [15:0] retrip_dly_q, retrip_dly_d, backup_dly_q, backup_dly_d, pulse_ms_q, pulse_ms_d;
	logic [7:0] ph_thr_q, ph_thr_d, res_thr_q, res_thr_d;
	logic [31:0] rdata_q, rdata_d;
	logic clear_cmd, backup_trip_q, backup_trip_d;
	logic [2:0] retrip_q, retrip_d;
	logic [NCH-1:0] act_q, act_d;
	logic [15:0] clamped;
	// settings are clamped into their legal range on write
	always_comb begin
		mode_d = mode_q;
		retrip_en_d = retrip_en_q;
		retrip_dly_d = retrip_dly_q;
		backup_dly_d = backup_dly_q;
		pulse_ms_d = pulse_ms_q;
		ph_thr_d = ph_thr_q;
		res_thr_d = res_thr_q;
		rdata_d = 32'h0000_0000;
		clamped = 16'h0000;
		clear_cmd = reg_wr_i && (reg_addr_i == `BF_CTRL_OFS) && reg_wdata_i[`BF_CTRL_CLEAR_BIT];
		if (reg_wr_i) begin
			case (reg_addr_i)
				`BF_CTRL_OFS: begin
					mode_d = op_mode_t'(reg_wdata_i[`BF_CTRL_MODE_MSB:`BF_CTRL_MODE_LSB]);
					retrip_en_d = reg_wdata_i[`BF_CTRL_RETRIP_BIT];
				end
				`BF_RETRIP_DLY_OFS: retrip_dly_d = clamp16(reg_wdata_i, `BF_RETRIP_MIN, `BF_RETRIP_MAX);
				`BF_BACKUP_DLY_OFS: backup_dly_d = clamp16(reg_wdata_i, `BF_BACKUP_MIN, `BF_BACKUP_MAX);
				`BF_PULSE_OFS: pulse_ms_d = clamp16(reg_wdata_i, `BF_PULSE_MIN, `BF_PULSE_MAX);
				`BF_PH_THR_OFS: begin
					clamped = clamp16(reg_wdata_i, `BF_PH_THR_MIN, `BF_PH_THR_MAX);
					ph_thr_d = clamped[7:0];
				end
				`BF_RES_THR_OFS: begin
					clamped = clamp16(reg_wdata_i, `BF_RES_THR_MIN, `BF_RES_THR_MAX);
					res_thr_d = clamped[7:0];
				end
				default: ;
			endcase
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				`BF_CTRL_OFS: rdata_d = {29'h0000_0000, retrip_en_q, mode_q};
				`BF_RETRIP_DLY_OFS: rdata_d = {16'h0000, retrip_dly_q};
				`BF_BACKUP_DLY_OFS: rdata_d = {16'h0000, backup_dly_q};
				`BF_PULSE_OFS: rdata_d = {16'h0000, pulse_ms_q};
				`BF_PH_THR_OFS: rdata_d = {24'h00_0000, ph_thr_q};
				`BF_RES_THR_OFS: rdata_d = {24'h00_0000, res_thr_q};
				`BF_STATUS_OFS: rdata_d = {24'h00_0000, act_q, retrip_q, backup_trip_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_q <= OP_OFF;
			retrip_en_q <= 1'b0;
			retrip_dly_q <= `BF_RETRIP_DEF;
			backup_dly_q <= `BF_BACKUP_DEF;
			pulse_ms_q <= `BF_PULSE_DEF;
			ph_thr_q <= `BF_PH_THR_DEF;
			res_thr_q <= `BF_RES_THR_DEF;
			rdata_q <= 32'h0000_0000;
		end else begin
			mode_q <= mode_d;
			retrip_en_q <= retrip_en_d;
			retrip_dly_q <= retrip_dly_d;
			backup_dly_q <= backup_dly_d;
			pulse_ms_q <= pulse_ms_d;
			ph_thr_q <= ph_thr_d;
			res_thr_q <= res_thr_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// millisecond tick
	logic [TW-1:0] tick_cnt_q, tick_cnt_d;
	logic tick;
	always_comb begin
		tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));
		tick_cnt_d = tick ? '0 : tick_cnt_q + TW'(1);
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	// ==========================================================
	// variant wiring and supervision
	logic [NCH-1:0] start_vec, cur_vec, closed_vec, fail_vec;
	logic any_ph_over, any_ph_closed, kill;
	always_comb begin
		any_ph_over = over_current_ph1_i | over_current_ph2_i | over_current_ph3_i;
		any_ph_closed = breaker_closed_ph1_i | breaker_closed_ph2_i | breaker_closed_ph3_i;
		if (SINGLE_POLE) begin
			// the common start also launches every phase in the single-pole variant
			start_vec = {residual_start_in_i, start_ph3_i | common_start_in_i,
				start_ph2_i | common_start_in_i, start_ph1_i | common_start_in_i};
			closed_vec = {any_ph_closed, breaker_closed_ph3_i, breaker_closed_ph2_i, breaker_closed_ph1_i};
			cur_vec = {over_current_res_i, over_current_ph3_i | over_current_res_i,
				over_current_ph2_i | over_current_res_i, over_current_ph1_i | over_current_res_i};
		end else begin
			start_vec = {residual_start_in_i, 2'b00, common_start_in_i};
			closed_vec = {breaker_closed_in_i, 2'b00, breaker_closed_in_i};
			cur_vec = {over_current_res_i, 2'b00, any_ph_over | over_current_res_i};
		end
		unique case (mode_q)
			OP_OFF: fail_vec = '0;
			OP_CURRENT: fail_vec = cur_vec;
			OP_CONTACT: fail_vec = closed_vec;
			OP_BOTH: fail_vec = cur_vec | closed_vec;
		endcase
		kill = block_in_i | (mode_q == OP_OFF) | clear_cmd;
	end

	// ==========================================================
	// per-channel backup and retrip timers
	logic [NCH-1:0] start_prev_q, start_prev_d, bu_fire;
	logic [2:0] rt_fire;
	logic [15:0] bu_cnt_q [NCH], bu_cnt_d [NCH];
	logic [15:0] rt_cnt_q [NCH], rt_cnt_d [NCH];
	always_comb begin
		start_prev_d = start_vec;
		act_d = act_q;
		bu_cnt_d = bu_cnt_q;
		rt_cnt_d = rt_cnt_q;
		for (int i = 0; i < NCH; i++) begin
			if (kill || !start_vec[i]) begin
				act_d[i] = 1'b0;
				bu_cnt_d[i] = 16'h0000;
				rt_cnt_d[i] = 16'h0000;
			end else if (!start_prev_q[i]) begin
				act_d[i] = 1'b1;
				bu_cnt_d[i] = 16'h0000;
				rt_cnt_d[i] = 16'h0000;
			end else if (act_q[i] && tick) begin
				// counters saturate at the setting so they can never wrap past expiry
				if (bu_cnt_q[i] < backup_dly_q) begin
					bu_cnt_d[i] = bu_cnt_q[i] + 16'h0001;
				end
				if (rt_cnt_q[i] < retrip_dly_q) begin
					rt_cnt_d[i] = rt_cnt_q[i] + 16'h0001;
				end
			end
		end
		for (int i = 0; i < NCH; i++) begin
			bu_fire[i] = act_q[i] && (bu_cnt_q[i] >= backup_dly_q) && fail_vec[i];
		end
		for (int i = 0; i < 3; i++) begin
			rt_fire[i] = SINGLE_POLE && retrip_en_q && act_q[i] && (rt_cnt_q[i] >= retrip_dly_q) && fail_vec[i];
		end
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			start_prev_q <= '0;
			act_q <= '0;
			for (int i = 0; i < NCH; i++) begin
				bu_cnt_q[i] <= 16'h0000;
				rt_cnt_q[i] <= 16'h0000;
			end
		end else begin
			start_prev_q <= start_prev_d;
			act_q <= act_d;
			bu_cnt_q <= bu_cnt_d;
			rt_cnt_q <= rt_cnt_d;
		end
	end

	// ==========================================================
	// trip outputs with minimum pulse length
	logic [16:0] bu_hold_q, bu_hold_d;
	logic [16:0] rt_hold_q [3], rt_hold_d [3];
	logic [16:0] pulse_load;
	// one extra tick is loaded because the first tick may come right after firing
	always_comb begin
		pulse_load = (pulse_ms_q == 16'h0000) ? 17'h00000 : {1'b0, pulse_ms_q} + 17'h00001;
		bu_hold_d = bu_hold_q;
		if (|bu_fire) begin
			bu_hold_d = pulse_load;
		end else if (tick && bu_hold_q != 17'h00000) begin
			bu_hold_d = bu_hold_q - 17'h00001;
		end
		if (kill) begin
			bu_hold_d = 17'h00000;
		end
		backup_trip_d = !kill && ((|bu_fire) || bu_hold_q != 17'h00000);
		for (int i = 0; i < 3; i++) begin
			rt_hold_d[i] = rt_hold_q[i];
			if (rt_fire[i]) begin
				rt_hold_d[i] = pulse_load;
			end else if (tick && rt_hold_q[i] != 17'h00000) begin
				rt_hold_d[i] = rt_hold_q[i] - 17'h00001;
			end
			if (kill || !SINGLE_POLE) begin
				rt_hold_d[i] = 17'h00000;
			end
			retrip_d[i] = !kill && SINGLE_POLE && (rt_fire[i] || rt_hold_q[i] != 17'h00000);
		end
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bu_hold_q <= 17'h00000;
			backup_trip_q <= 1'b0;
			retrip_q <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				rt_hold_q[i] <= 17'h00000;
			end
		end else begin
			bu_hold_q <= bu_hold_d;
			backup_trip_q <= backup_trip_d;
			retrip_q <= retrip_d;
			rt_hold_q <= rt_hold_d;
		end
	end
	assign reg_rdata_o = rdata_q;
	assign phase_threshold_o = ph_thr_q;
	assign residual_threshold_o = res_thr_q;
	assign backup_trip_out_o = backup_trip_q;
	assign retrip_ph1_o = retrip_q[0];
	assign retrip_ph2_o = retrip_q[1];
	assign retrip_ph3_o = retrip_q[2];
	// ==========================================================
	// assertions
	a_off_no_trip:
	assert property (@(posedge core_clk_i) disable iff (rst_i) (mode_q == OP_OFF) |=> !backup_trip_q && retrip_q == 3'h0)
		else $error("trip output while mode is off");
	a_block_no_trip:
	assert property (@(posedge core_clk_i) disable iff (rst_i) block_in_i |=> !backup_trip_q && retrip_q == 3'h0)
		else $error("trip output while blocked");
	a_start_launch:
	assert property (@(posedge core_clk_i) disable iff (rst_i)
		start_vec[0] && !start_prev_q[0] && !kill |=> act_q[0] && bu_cnt_q[0] == 16'h0000 && rt_cnt_q[0] == 16'h0000)
		else $error("start edge did not launch timers");
	a_timer_cleared:
	assert property (@(posedge core_clk_i) disable iff (rst_i) (!start_vec[0] || block_in_i) |=> !act_q[0] && bu_cnt_q[0] == 16'h0000)
		else $error("timer not cleared on start fall or block");
	a_pulse_hold:
	assert property (@(posedge core_clk_i) disable iff (rst_i)
		$rose(backup_trip_q) && pulse_ms_q != 16'h0000 && !kill |=> backup_trip_q)
		else $error("backup trip shorter than pulse setting");
	a_backup_cause:
	assert property (@(posedge core_clk_i) disable iff (rst_i) $rose(backup_trip_q) |-> $past(|bu_fire))
		else $error("backup trip without expired timer and failure");
	a_retrip_cause:
	assert property (@(posedge core_clk_i) disable iff (rst_i) $rose(retrip_q[0]) |-> $past(rt_fire[0]) && $past(retrip_en_q))
		else $error("retrip without expired retrip timer");
	a_clear_cmd:
	assert property (@(posedge core_clk_i) disable iff (rst_i) clear_cmd |=> act_q == '0 && !backup_trip_q && retrip_q == 3'h0)
		else $error("clear did not empty timers and trips");
	a_delay_range:
	assert property (@(posedge core_clk_i) disable iff (rst_i) backup_dly_q >= `BF_BACKUP_MIN && backup_dly_q <= `BF_BACKUP_MAX)
		else $error("backup delay out of range");
	a_contact_mode:
	assert property (@(posedge core_clk_i) disable iff (rst_i)
		(mode_q == OP_CONTACT) && closed_vec == '0 && bu_hold_q == 17'h00000 |=> !backup_trip_q)
		else $error("contact mode tripped with every breaker open");
endmodule // breaker_failure_decision_logic
`default_nettype wire

// ===== dv/protection_logic_model.sv
// model of the user protection logic that drives starts, block, breaker state and current flags
`default_nettype none
module protection_logic_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic block_cmd_i,
	input wire logic [4:0] start_cmd_i,
	input wire logic [3:0] closed_cmd_i,
	input wire logic [3:0] oc_cmd_i,
	output logic block_o,
	output logic [4:0] start_o,
	output logic [3:0] closed_o,
	output logic [3:0] oc_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================
	// equation outputs, updated just after each edge like any registered user logic
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			block_o <= 1'b0;
			start_o <= 5'h00;
			closed_o <= 4'h0;
			oc_o <= 4'h0;
		end else begin
			block_o <= block_cmd_i;
			start_o <= start_cmd_i;
			closed_o <= closed_cmd_i;
			oc_o <= oc_cmd_i;
		end
	end
endmodule // protection_logic_model
`default_nettype wire

// ===== dv/breaker_failure_decision_logic_tb.sv
// self-checking bench for the breaker failure decision logic, both variants
`default_nettype none
module breaker_failure_decision_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst, wr, rd_s, blk_c, blk;
	logic [7:0] addr, ph_thr, res_thr;
	logic [31:0] wdata, rdata;
	logic [4:0] st_c, st;
	logic [3:0] cl_c, cl, oc_c, oc;
	logic bk, r1, r2, r3, cv_bk, cv_r1, cv_r2, cv_r3;
	logic [5:0] trips;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	int t0 = 0;
	assign trips = {cv_r1 | cv_r2 | cv_r3, cv_bk, r3, r2, r1, bk};
	protection_logic_model protection_logic_model_i (.core_clk_i(core_clk), .rst_i(rst), .block_cmd_i(blk_c),
		.start_cmd_i(st_c), .closed_cmd_i(cl_c), .oc_cmd_i(oc_c), .block_o(blk), .start_o(st), .closed_o(cl),
		.oc_o(oc));
	breaker_failure_decision_logic #(.SINGLE_POLE(1'b1), .TICK_CYCLES(4)) breaker_failure_decision_logic_i (
		.core_clk_i(core_clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd_s), .reg_rdata_o(rdata), .block_in_i(blk), .common_start_in_i(st[0]), .start_ph1_i(st[1]),
		.start_ph2_i(st[2]), .start_ph3_i(st[3]), .residual_start_in_i(st[4]), .breaker_closed_in_i(cl[0]),
		.breaker_closed_ph1_i(cl[1]), .breaker_closed_ph2_i(cl[2]), .breaker_closed_ph3_i(cl[3]),
		.over_current_ph1_i(oc[0]), .over_current_ph2_i(oc[1]), .over_current_ph3_i(oc[2]),
		.over_current_res_i(oc[3]), .phase_threshold_o(ph_thr), .residual_threshold_o(res_thr),
		.backup_trip_out_o(bk), .retrip_ph1_o(r1), .retrip_ph2_o(r2), .retrip_ph3_o(r3));
	// common-phase build shares the bus, so it always carries the same settings
	breaker_failure_decision_logic #(.SINGLE_POLE(1'b0), .TICK_CYCLES(4)) breaker_failure_decision_logic_cv_i (
		.core_clk_i(core_clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd_s), .reg_rdata_o(), .block_in_i(blk), .common_start_in_i(st[0]), .start_ph1_i(st[1]),
		.start_ph2_i(st[2]), .start_ph3_i(st[3]), .residual_start_in_i(st[4]), .breaker_closed_in_i(cl[0]),
		.breaker_closed_ph1_i(cl[1]), .breaker_closed_ph2_i(cl[2]), .breaker_closed_ph3_i(cl[3]),
		.over_current_ph1_i(oc[0]), .over_current_ph2_i(oc[1]), .over_current_ph3_i(oc[2]),
		.over_current_res_i(oc[3]), .phase_threshold_o(), .residual_threshold_o(),
		.backup_trip_out_o(cv_bk), .retrip_ph1_o(cv_r1), .retrip_ph2_o(cv_r2), .retrip_ph3_o(cv_r3));
	// =========================================
	// clock, cycle count and hang guard
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			n_fail++;
			complete_run();
		end
	end
	// =========================================
	// tasks
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_out(input string what, input logic [5:0] exp, input logic [5:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd_s <= 1'b0;
		#1;
		chk_reg("read data", exp, rdata);
	endtask
	task automatic go(input logic b, input logic [4:0] s, input logic [3:0] c, input logic [3:0] o);
		@(posedge core_clk);
		blk_c <= b;
		st_c <= s;
		cl_c <= c;
		oc_c <= o;
		t0 = cyc;
	endtask
	// waits for one trip bit to reach a level; it must not get there before lo cycles or after hi
	task automatic wait_out(input int idx, input logic v, input int lo, input int hi);
		while (trips[idx] !== v && cyc - t0 <= hi) begin
			@(posedge core_clk);
			#1;
		end
		chk_out("trip timing", 6'h01, {5'h00, trips[idx] === v && cyc - t0 >= lo && cyc - t0 <= hi});
	endtask
	task automatic hold_out(input logic [5:0] exp, input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1;
			chk_out("trips steady", exp, trips);
		end
	endtask
	task automatic end_test(input string name);
		$display("test %s done", name);
		go(1'b0, 5'h00, 4'h0, 4'h0);
		repeat (40) @(posedge core_clk);
		#1;
		chk_out("trips idle", 6'h00, trips);
	endtask
	// =========================================
	// main sequence
	initial begin
		rst = 1'b1;
		{wr, rd_s, blk_c, addr, wdata, st_c, cl_c, oc_c} = '0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		rd_reg(8'h00, 32'h0);
		rd_reg(8'h04, 32'h64);
		rd_reg(8'h08, 32'h3e8);
		rd_reg(8'h0c, 32'h64);
		rd_reg(8'h10, 32'h1e);
		rd_reg(8'h14, 32'h14);
		chk_reg("residual threshold", 32'h14, {24'h0, res_thr});
		rd_reg(8'h1c, 32'h0);
		wr_reg(8'h04, 32'h7d0);
		rd_reg(8'h04, 32'h3e8);
		wr_reg(8'h08, 32'h5);
		rd_reg(8'h08, 32'h64);
		wr_reg(8'h0c, 32'h11170);
		rd_reg(8'h0c, 32'hea60);
		wr_reg(8'h10, 32'h5);
		#1;
		chk_reg("phase threshold", 32'h14, {24'h0, ph_thr});
		wr_reg(8'h14, 32'hfa);
		#1;
		chk_reg("residual threshold", 32'hc8, {24'h0, res_thr});
		rd_reg(8'h14, 32'hc8);
		wr_reg(8'h04, 32'ha);
		wr_reg(8'h0c, 32'h5);
		end_test("registers");
		wr_reg(8'h00, 32'h5);
		go(1'b0, 5'h06, 4'h4, 4'h1);
		wait_out(1, 1'b1, 40, 50);
		wait_out(0, 1'b1, 400, 410);
		chk_out("retrip ph2", 6'h00, {5'h00, trips[2]});
		rd_reg(8'h18, 32'h33);
		go(1'b0, 5'h06, 4'h4, 4'h0);
		hold_out(6'h03, 18);
		wait_out(0, 1'b0, 20, 32);
		end_test("current");
		wr_reg(8'h00, 32'h6);
		go(1'b0, 5'h0c, 4'h4, 4'h4);
		wait_out(2, 1'b1, 40, 50);
		wait_out(0, 1'b1, 400, 410);
		chk_out("retrip ph3", 6'h00, {5'h00, trips[3]});
		end_test("contact");
		wr_reg(8'h00, 32'h7);
		go(1'b0, 5'h0a, 4'h8, 4'h1);
		wait_out(1, 1'b1, 40, 50);
		wait_out(3, 1'b1, 0, 50);
		wait_out(0, 1'b1, 400, 410);
		go(1'b0, 5'h0a, 4'h8, 4'h0);
		repeat (40) @(posedge core_clk);
		#1;
		chk_out("backup held", 6'h01, {5'h00, trips[0]});
		go(1'b0, 5'h0a, 4'h0, 4'h0);
		wait_out(0, 1'b0, 20, 32);
		end_test("both");
		wr_reg(8'h00, 32'h4);
		go(1'b0, 5'h03, 4'h3, 4'h1);
		hold_out(6'h00, 420);
		end_test("off");
		wr_reg(8'h00, 32'h5);
		go(1'b1, 5'h02, 4'h0, 4'h1);
		hold_out(6'h00, 420);
		end_test("block held");
		go(1'b0, 5'h02, 4'h0, 4'h1);
		wait_out(1, 1'b1, 40, 50);
		go(1'b1, 5'h02, 4'h0, 4'h1);
		wait_out(1, 1'b0, 0, 3);
		end_test("block mid trip");
		go(1'b0, 5'h02, 4'h0, 4'h1);
		wait_out(1, 1'b1, 40, 50);
		wr_reg(8'h00, 32'hd);
		@(posedge core_clk);
		#1;
		chk_out("after clear", 6'h00, trips);
		rd_reg(8'h00, 32'h5);
		end_test("clear");
		wr_reg(8'h00, 32'h5);
		go(1'b0, 5'h10, 4'h0, 4'h8);
		wait_out(0, 1'b1, 400, 410);
		wait_out(4, 1'b1, 400, 410);
		chk_out("residual retrips", 6'h00, {3'h0, trips[3:1]});
		end_test("residual");
		wr_reg(8'h00, 32'h2);
		go(1'b0, 5'h01, 4'h3, 4'h0);
		wait_out(4, 1'b1, 400, 410);
		chk_out("variant split", 6'h11, trips);
		end_test("common variant");
		complete_run();
	end
endmodule // breaker_failure_decision_logic_tb
`default_nettype wire
